/* hdl/csp_clock_ctrl.sv */
// clock sources, fractional pll and cpu prescaler control
`timescale 1ns/1ps
`default_nettype none

// How it works
// R1: cpu clock enable fires once every two-to-the-divider-field main clock cycles.
// R2: software clears crystal enable alone; a clearing write touches only that bit.
// R3: crystal oscillator keeps running in sleep; no sleep input stops it.
// R4: crystal output stays masked for the whole selected start-up interval.
// R5: crystal ready flag sets when the selected start-up interval has elapsed.
// R6: ready interrupt pulses on crystal ready rising, only when enabled.
// R7: crystal state survives ordinary reset; only power-on reset stops it.
// R8: crystal 32k output runs when enabled and a crystal is fitted.
// R9: software waits for every ready flag before requesting standby.
// R10: internal oscillator is off after reset; its enable bit starts and stops it.
// R11: internal oscillator drives its 32k output when its output enable is set.
// R12: trim sets internal frequency; new trim commits when internal ready rises. The code keeps the old trim for a write in IO_START or as IO_TRIM ends.
// R13: software loads factory trim itself; hardware applies none.
// R14: software enables the lock timer clock before using the pll lock timer.
// R15: pll output rate is reference times int ratio plus one plus frac/16.
// R16: main oscillator reference is divided by two times divider plus one.
// R17: pll reference selects crystal 32k, main oscillator or generic clock.
// R18: disabled pll holds its output clock in reset.
// R19: pll is integer mode with zero fractional ratio, fractional otherwise.
// R20: eight generic clock pins feed generators as inputs or carry clocks out.
// R21: software keeps the divided main oscillator within the pll input range.
module csp_clock_ctrl
	import csp_pkg::*;
#(
	parameter int LOCK_EDGES = PLL_LOCK_EDGES,
	parameter int HALF_NOM   = INT_HALF_CYC
) (
	input  wire logic                    ref_clk,
	input  wire logic                    rst,
	input  wire logic                    por_rst,
	input  wire logic [7:0]              addr,
	input  wire logic [31:0]             wr_data,
	input  wire logic                    wr_stb,
	input  wire logic                    rd_stb,
	output var  logic [31:0]             rd_data,
	input  wire logic                    crystal_in_pin_32k,
	input  wire logic                    main_xosc_in,
	input  wire logic                    pll_ref_gen_clock,
	input  wire logic                    pll_lock_timer_clock,
	input  wire logic [NUM_GEN_PINS-1:0] gen_clock_pin_in,
	output var  logic [NUM_GEN_PINS-1:0] gen_clock_pin_out,
	output var  logic [NUM_GEN_PINS-1:0] gen_clock_pin_oe_n,
	input  wire logic [NUM_GEN_PINS-1:0] gen_clk_from_gen,
	output var  logic [NUM_GEN_PINS-1:0] gen_src_to_gen,
	output var  logic                    cpu_clk_en,
	output var  logic                    xt_clk,
	output var  logic                    xt_out_32k,
	output var  logic                    io_clk,
	output var  logic                    io_out_32k,
	output var  logic                    pll_ref_clock,
	output var  logic                    pll_out_clock,
	output var  logic                    crystal32_ready_irq
);
	initial begin
		if (LOCK_EDGES < 1 || LOCK_EDGES > 65535 || HALF_NOM < 128 || HALF_NOM > 65000)
			$error("csp_clock_ctrl: parameter out of range");
	end

	localparam int NS = NUM_GEN_PINS + 4;

	// three-stage pin sampling; a change counts once stages two and three agree
	logic [NS-1:0] s1_q, s2_q, s3_q, flt_q, flt_d, rise;
	always_comb begin
		flt_d = flt_q;
		for (int i = 0; i < NS; i++) begin
			if (s2_q[i] == s3_q[i])
				flt_d[i] = s3_q[i];
		end
		rise = flt_d & ~flt_q;
	end
	always_ff @(posedge ref_clk) begin
		// only power-on clears the samplers so the crystal path rides through ordinary reset [R7]
		if (por_rst) begin
			s1_q  <= '0;
			s2_q  <= '0;
			s3_q  <= '0;
			flt_q <= '0;
		end else begin
			s1_q  <= {gen_clock_pin_in, pll_lock_timer_clock, pll_ref_gen_clock, main_xosc_in, crystal_in_pin_32k};
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			flt_q <= flt_d;
		end
	end
	wire logic xt_rise   = rise[0];
	wire logic xo_rise   = rise[1];
	wire logic gen_rise  = rise[2];
	wire logic lock_rise = rise[3];

	// register file
	logic [2:0]     cpu_div_field_q, cpu_div_field_d;
	logic           irq_en_q, irq_en_d;
	csp_xt_ctrl_t   xt_ctrl_q, xt_ctrl_d;
	csp_io_ctrl_t   io_ctrl_q, io_ctrl_d;
	csp_pll_ctrl_t  pll_ctrl_q, pll_ctrl_d;
	csp_pll_ratio_t pll_ratio_reg_q, pll_ratio_reg_d;
	logic [NUM_GEN_PINS-1:0] pin_dir_q, pin_dir_d;
	logic           trim_wr;
	csp_status_t    clock_status_reg;
	logic [31:0]    rd_data_q, rd_data_d;
	always_comb begin
		cpu_div_field_d = cpu_div_field_q;
		irq_en_d        = irq_en_q;
		xt_ctrl_d       = xt_ctrl_q;
		io_ctrl_d       = io_ctrl_q;
		pll_ctrl_d      = pll_ctrl_q;
		pll_ratio_reg_d = pll_ratio_reg_q;
		pin_dir_d       = pin_dir_q;
		trim_wr         = 1'b0;
		rd_data_d       = 32'h0000_0000;
		if (wr_stb) begin
			unique case (addr)
				ADDR_IRQ_EN:    irq_en_d = wr_data[0];
				ADDR_CPU_CLOCK_DIVIDER_SELECT:    cpu_div_field_d = wr_data[2:0];
				ADDR_XT_CTRL: begin
					// a disabling write keeps every other field as it was [R2]
					if (!wr_data[0])
						xt_ctrl_d.enable = 1'b0;
					else
						xt_ctrl_d = {wr_data[10:8], wr_data[2], wr_data[1], 1'b1};
				end
				ADDR_IO_CTRL: begin
					io_ctrl_d = {wr_data[22:16], wr_data[2], wr_data[0]}; // [R10]
					trim_wr   = (wr_data[22:16] != io_ctrl_q.trim_value);
				end
				ADDR_PLL_CTRL:  pll_ctrl_d = {wr_data[26:16], wr_data[2:1], wr_data[0]};
				ADDR_PLL_RATIO: pll_ratio_reg_d = {wr_data[19:16], wr_data[11:0]};
				ADDR_PIN_DIR:   pin_dir_d = wr_data[NUM_GEN_PINS-1:0];
				default: ;
			endcase
		end
		if (rd_stb) begin
			unique case (addr)
				ADDR_STATUS:    rd_data_d = {28'h0, clock_status_reg};
				ADDR_IRQ_EN:    rd_data_d = {31'h0, irq_en_q};
				ADDR_CPU_CLOCK_DIVIDER_SELECT:    rd_data_d = {29'h0, cpu_div_field_q};
				ADDR_XT_CTRL:   rd_data_d = {21'h0, xt_ctrl_q.startup, 5'h0, xt_ctrl_q.out_32k_enable,
				                             xt_ctrl_q.crystal_fitted, xt_ctrl_q.enable};
				ADDR_IO_CTRL:   rd_data_d = {9'h0, io_ctrl_q.trim_value, 13'h0, io_ctrl_q.out_32k_enable,
				                             1'b0, io_ctrl_q.enable};
				ADDR_PLL_CTRL:  rd_data_d = {5'h0, pll_ctrl_q.ref_div, 13'h0, pll_ctrl_q.ref_sel, pll_ctrl_q.enable};
				ADDR_PLL_RATIO: rd_data_d = {12'h0, pll_ratio_reg_q.loop_ratio_frac, 4'h0,
				                             pll_ratio_reg_q.loop_ratio_int};
				ADDR_PIN_DIR:   rd_data_d = {{(32-NUM_GEN_PINS){1'b0}}, pin_dir_q};
				default:        rd_data_d = 32'h0000_0000;
			endcase
		end
	end
	always_ff @(posedge ref_clk) begin
		// crystal control sees only power-on reset [R7]
		if (por_rst)
			xt_ctrl_q <= '0;
		else
			xt_ctrl_q <= xt_ctrl_d;
		if (rst || por_rst) begin
			cpu_div_field_q <= CPU_CLOCK_DIVIDER_SELECT_RST;
			irq_en_q        <= 1'b0;
			io_ctrl_q       <= {IO_TRIM_MID, 1'b0, 1'b0};
			pll_ctrl_q      <= '0;
			pll_ratio_reg_q <= '0;
			pin_dir_q       <= '0;
			rd_data_q       <= 32'h0000_0000;
		end else begin
			cpu_div_field_q <= cpu_div_field_d;
			irq_en_q        <= irq_en_d;
			io_ctrl_q       <= io_ctrl_d;
			pll_ctrl_q      <= pll_ctrl_d;
			pll_ratio_reg_q <= pll_ratio_reg_d;
			pin_dir_q       <= pin_dir_d;
			rd_data_q       <= rd_data_d;
		end
	end

	// cpu prescaler
	logic [6:0] cpu_cnt_q, cpu_cnt_d;
	logic       cpu_en_q, cpu_en_d;
	always_comb begin
		cpu_cnt_d = cpu_cnt_q + 7'h01;
		cpu_en_d  = 1'b0;
		if (cpu_cnt_q >= 7'((8'h01 << cpu_div_field_q) - 8'h01)) begin
			cpu_cnt_d = 7'h00;
			cpu_en_d  = 1'b1; // [R1]
		end
	end
	always_ff @(posedge ref_clk) begin
		if (rst || por_rst) begin
			cpu_cnt_q <= 7'h00;
			cpu_en_q  <= 1'b0;
		end else begin
			cpu_cnt_q <= cpu_cnt_d;
			cpu_en_q  <= cpu_en_d;
		end
	end

	// crystal 32k oscillator; no sleep term here on purpose [R3]
	csp_xt_state_t xt_st_q, xt_st_d;
	logic [10:0]   xt_cnt_q, xt_cnt_d;
	logic          xt_clk_q, xt_clk_d, xt_o32_q, xt_o32_d, xt_irq_q, xt_irq_d;
	always_comb begin
		xt_st_d  = xt_st_q;
		xt_cnt_d = xt_cnt_q;
		unique case (xt_st_q)
			XT_OFF: begin
				xt_cnt_d = 11'h000;
				if (xt_ctrl_q.enable)
					xt_st_d = XT_START;
			end
			XT_START: begin
				if (!xt_ctrl_q.enable)
					xt_st_d = XT_OFF;
				else if (xt_cnt_q >= 11'(12'h001 << (4'(xt_ctrl_q.startup) + 4'(XT_STARTUP_BASE))))
					xt_st_d = XT_READY; // [R5]
				else if (xt_rise)
					xt_cnt_d = xt_cnt_q + 11'h001;
			end
			XT_READY: if (!xt_ctrl_q.enable) xt_st_d = XT_OFF;
			default: xt_st_d = XT_OFF;
		endcase
		// masked until ready so start-up wobble never leaves the block [R4]
		xt_clk_d = (xt_st_q == XT_READY) && flt_q[0];
		xt_o32_d = xt_clk_d && xt_ctrl_q.out_32k_enable && xt_ctrl_q.crystal_fitted; // [R8]
		xt_irq_d = (xt_st_d == XT_READY) && (xt_st_q != XT_READY) && irq_en_q; // [R6]
	end
	always_ff @(posedge ref_clk) begin
		if (por_rst) begin // [R7]
			xt_st_q  <= XT_OFF;
			xt_cnt_q <= 11'h000;
			xt_clk_q <= 1'b0;
			xt_o32_q <= 1'b0;
		end else begin
			xt_st_q  <= xt_st_d;
			xt_cnt_q <= xt_cnt_d;
			xt_clk_q <= xt_clk_d;
			xt_o32_q <= xt_o32_d;
		end
		if (rst || por_rst)
			xt_irq_q <= 1'b0;
		else
			xt_irq_q <= xt_irq_d;
	end

	// internal 32k oscillator; half period moves one cycle per trim step
	csp_io_state_t io_st_q, io_st_d;
	logic [15:0]   io_div_q, io_div_d, io_half;
	logic [2:0]    io_edges_q, io_edges_d;
	logic          io_clk_q, io_clk_d, io_o32_q, io_o32_d;
	logic [6:0]    io_trim_q, io_trim_d;
	always_comb begin
		io_st_d    = io_st_q;
		io_edges_d = io_edges_q;
		io_trim_d  = io_trim_q;
		io_half    = 16'(HALF_NOM) - 16'(IO_TRIM_MID) + {9'h000, io_trim_q}; // [R12]
		io_div_d   = io_div_q + 16'h0001;
		io_clk_d   = io_clk_q;
		if (io_st_q == IO_OFF) begin
			io_div_d = 16'h0000;
			io_clk_d = 1'b0;
		end else if (io_div_q >= io_half - 16'h0001) begin
			io_div_d = 16'h0000;
			io_clk_d = ~io_clk_q;
		end
		if (io_clk_d && !io_clk_q && io_edges_q != 3'h7)
			io_edges_d = io_edges_q + 3'h1;
		unique case (io_st_q)
			IO_OFF: begin
				io_edges_d = 3'h0;
				io_trim_d  = io_ctrl_q.trim_value;
				if (io_ctrl_q.enable)
					io_st_d = IO_START; // [R10]
			end
			IO_START: if (io_edges_q >= 3'(IO_STARTUP_EDGE)) io_st_d = IO_READY;
			IO_READY: if (trim_wr) begin
				io_st_d    = IO_TRIM;
				io_edges_d = 3'h0;
			end
			IO_TRIM: if (io_edges_q >= 3'(IO_TRIM_SETTLE)) begin
				// trim commits together with ready rising [R12]
				io_trim_d = io_ctrl_q.trim_value;
				io_st_d   = IO_READY;
			end
		endcase
		if (!io_ctrl_q.enable)
			io_st_d = IO_OFF; // [R10]
		io_o32_d = io_clk_d && io_ctrl_q.out_32k_enable && (io_st_d != IO_OFF); // [R11]
	end
	always_ff @(posedge ref_clk) begin
		if (rst || por_rst) begin
			io_st_q    <= IO_OFF;
			io_div_q   <= 16'h0000;
			io_edges_q <= 3'h0;
			io_clk_q   <= 1'b0;
			io_o32_q   <= 1'b0;
			io_trim_q  <= IO_TRIM_MID;
		end else begin
			io_st_q    <= io_st_d;
			io_div_q   <= io_div_d;
			io_edges_q <= io_edges_d;
			io_clk_q   <= io_clk_d;
			io_o32_q   <= io_o32_d;
			io_trim_q  <= io_trim_d;
		end
	end

	// fractional pll: measures reference period, phase accumulator makes output ticks
	csp_pll_state_t pl_st_q, pl_st_d;
	logic [11:0] xo_cnt_q, xo_cnt_d;
	logic        ref_tick;
	logic        ref_q, ref_d, out_q, out_d;
	logic [15:0] per_cnt_q, per_cnt_d, per_q, per_d, lock_q, lock_d;
	logic [20:0] acc_q, acc_d, mult, wrap;
	always_comb begin
		xo_cnt_d = xo_cnt_q;
		ref_tick = 1'b0;
		unique case (pll_ctrl_q.ref_sel) // [R17]
			REF_XT32: ref_tick = xt_rise && (xt_st_q == XT_READY);
			REF_XOSC: if (xo_rise) begin
				// one reference edge per 2*(div+1) main oscillator edges [R16]
				if (xo_cnt_q >= 12'({pll_ctrl_q.ref_div, 1'b1})) begin
					xo_cnt_d = 12'h000;
					ref_tick = 1'b1;
				end else
					xo_cnt_d = xo_cnt_q + 12'h001;
			end
			REF_GEN:  ref_tick = gen_rise;
			default:  ref_tick = 1'b0;
		endcase
		ref_d     = ref_tick;
		per_cnt_d = (per_cnt_q == 16'hFFFF) ? per_cnt_q : per_cnt_q + 16'h0001;
		per_d     = per_q;
		if (ref_tick) begin
			per_d     = per_cnt_q;
			per_cnt_d = 16'h0001;
		end
		// output ticks per ref_clk cycle = (16*(int+1)+frac) / (16*period) [R15]
		mult  = {5'h00, pll_ratio_reg_q.loop_ratio_int + 12'h001, pll_ratio_reg_q.loop_ratio_frac};
		wrap  = {1'b0, per_q, 4'h0};
		acc_d = acc_q + mult;
		out_d = 1'b0;
		if (acc_d >= wrap && wrap != 21'h0) begin
			acc_d = acc_d - wrap;
			out_d = 1'b1; // saturates at one tick per cycle
		end
		lock_d  = lock_q;
		pl_st_d = pl_st_q;
		unique case (pl_st_q)
			PL_OFF:  if (pll_ctrl_q.enable) pl_st_d = PL_LOCK;
			PL_LOCK: if (lock_q >= 16'(LOCK_EDGES)) pl_st_d = PL_RUN;
				else if (lock_rise) lock_d = lock_q + 16'h0001;
			PL_RUN:  ;
			default: pl_st_d = PL_OFF;
		endcase
		if (pl_st_q != PL_RUN) begin
			acc_d = 21'h0;
			out_d = 1'b0;
		end
		if (!pll_ctrl_q.enable) begin
			// disabled pll keeps its output and lock state in reset [R18]
			pl_st_d = PL_OFF;
			lock_d  = 16'h0000;
			acc_d   = 21'h0;
			out_d   = 1'b0;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (rst || por_rst) begin
			pl_st_q   <= PL_OFF;
			xo_cnt_q  <= 12'h000;
			ref_q     <= 1'b0;
			out_q     <= 1'b0;
			per_cnt_q <= 16'h0000;
			per_q     <= 16'h0000;
			lock_q    <= 16'h0000;
			acc_q     <= 21'h0;
		end else begin
			pl_st_q   <= pl_st_d;
			xo_cnt_q  <= xo_cnt_d;
			ref_q     <= ref_d;
			out_q     <= out_d;
			per_cnt_q <= per_cnt_d;
			per_q     <= per_d;
			lock_q    <= lock_d;
			acc_q     <= acc_d;
		end
	end

	always_comb begin
		clock_status_reg.crystal32_ready  = (xt_st_q == XT_READY); // [R5]
		clock_status_reg.internal32_ready = (io_st_q == IO_READY); // [R12]
		clock_status_reg.pll_locked       = (pl_st_q == PL_RUN);
		clock_status_reg.pll_frac_mode    = (pll_ratio_reg_q.loop_ratio_frac != 4'h0); // [R19]
	end

	// generic clock pins: input feeds generators, output carries their clock
	logic [NUM_GEN_PINS-1:0] gp_out_q, gp_oen_q, gp_src_q;
	always_ff @(posedge ref_clk) begin
		if (rst || por_rst) begin
			gp_out_q <= '0;
			gp_oen_q <= '1;
			gp_src_q <= '0;
		end else begin
			gp_out_q <= gen_clk_from_gen & pin_dir_q;     // [R20]
			gp_oen_q <= ~pin_dir_q;                       // [R20]
			gp_src_q <= flt_q[NS-1:4] & ~pin_dir_q;       // [R20]
		end
	end

	assign rd_data             = rd_data_q;
	assign cpu_clk_en          = cpu_en_q;
	assign xt_clk              = xt_clk_q;
	assign xt_out_32k          = xt_o32_q;
	assign io_clk              = io_clk_q;
	assign io_out_32k          = io_o32_q;
	assign pll_ref_clock       = ref_q;
	assign pll_out_clock       = out_q;
	assign crystal32_ready_irq = xt_irq_q;
	assign gen_clock_pin_out   = gp_out_q;
	assign gen_clock_pin_oe_n  = gp_oen_q;
	assign gen_src_to_gen      = gp_src_q;
endmodule : csp_clock_ctrl

`default_nettype wire

/* include/csp_pkg.sv */
// constants, register layout and carrier types of the clock source block
package csp_pkg;
	localparam int          CLK_HZ          = 100_000_000;
	localparam int          OSC32_HZ        = 32_768;
	localparam int          INT_HALF_CYC    = CLK_HZ / (2 * OSC32_HZ);
	localparam logic [7:0]  ADDR_STATUS     = 8'h00;
	localparam logic [7:0]  ADDR_IRQ_EN     = 8'h04;
	localparam logic [7:0]  ADDR_CPU_CLOCK_DIVIDER_SELECT     = 8'h08;
	localparam logic [7:0]  ADDR_XT_CTRL    = 8'h0C;
	localparam logic [7:0]  ADDR_IO_CTRL    = 8'h10;
	localparam logic [7:0]  ADDR_PLL_CTRL   = 8'h14;
	localparam logic [7:0]  ADDR_PLL_RATIO  = 8'h18;
	localparam logic [7:0]  ADDR_PIN_DIR    = 8'h1C;
	localparam logic [2:0]  CPU_CLOCK_DIVIDER_SELECT_RST      = 3'h0;
	localparam int          XT_STARTUP_BASE = 3;
	localparam int          IO_STARTUP_EDGE = 4;
	localparam int          IO_TRIM_SETTLE  = 2;
	localparam logic [6:0]  IO_TRIM_MID     = 7'h40;
	localparam int          PLL_LOCK_EDGES  = 64;
	localparam logic [1:0]  REF_XT32        = 2'h0;
	localparam logic [1:0]  REF_XOSC        = 2'h1;
	localparam logic [1:0]  REF_GEN         = 2'h2;
	localparam int          FRAC_DEN        = 16;
	localparam int          NUM_GEN_PINS    = 8;

	typedef struct packed {
		logic [2:0] startup;
		logic       out_32k_enable;
		logic       crystal_fitted;
		logic       enable;
	} csp_xt_ctrl_t;

	typedef struct packed {
		logic [6:0] trim_value;
		logic       out_32k_enable;
		logic       enable;
	} csp_io_ctrl_t;

	typedef struct packed {
		logic [10:0] ref_div;
		logic [1:0]  ref_sel;
		logic        enable;
	} csp_pll_ctrl_t;

	typedef struct packed {
		logic [3:0]  loop_ratio_frac;
		logic [11:0] loop_ratio_int;
	} csp_pll_ratio_t;

	typedef struct packed {
		logic pll_frac_mode;
		logic pll_locked;
		logic internal32_ready;
		logic crystal32_ready;
	} csp_status_t;

	typedef enum logic [1:0] {XT_OFF = 2'b00, XT_START = 2'b01, XT_READY = 2'b11} csp_xt_state_t;
	typedef enum logic [1:0] {IO_OFF = 2'b00, IO_START = 2'b01, IO_READY = 2'b11, IO_TRIM = 2'b10} csp_io_state_t;
	typedef enum logic [1:0] {PL_OFF = 2'b00, PL_LOCK = 2'b01, PL_RUN = 2'b11} csp_pll_state_t;
endpackage : csp_pkg

/* testbench/csp_clock_ctrl_assertions.sv */
// port-level checks of the clock source block
`timescale 1ns/1ps
`default_nettype none
module csp_clock_ctrl_checker
	import csp_pkg::*;
(
	input wire logic                    ref_clk,
	input wire logic                    rst,
	input wire logic                    por_rst,
	input wire logic [7:0]              addr,
	input wire logic [31:0]             wr_data,
	input wire logic                    wr_stb,
	input wire logic                    cpu_clk_en,
	input wire logic [NUM_GEN_PINS-1:0] gen_clock_pin_oe_n,
	input wire logic [NUM_GEN_PINS-1:0] gen_src_to_gen,
	input wire logic                    xt_out_32k,
	input wire logic                    io_clk,
	input wire logic                    io_out_32k,
	input wire logic                    pll_ref_clock,
	input wire logic                    pll_out_clock,
	input wire logic                    crystal32_ready_irq
);
	logic [8:0] age_q;
	logic [7:0] gap_q;
	logic [7:0] dir_q;
	logic [2:0] div_q;
	logic       irq_en_q;
	logic       xt_out_q;
	logic       io_out_q;
	logic       io_on_q;
	logic       pll_on_q;
	// mirrors of control bits; age gates out the settling after any write
	always_ff @(posedge ref_clk) begin
		gap_q <= cpu_clk_en ? 8'h01 : gap_q + 8'h01;
		age_q <= (age_q == 9'h1FF) ? age_q : age_q + 9'h001;
		if (por_rst)
			xt_out_q <= 1'b0;
		if (rst || por_rst) begin
			age_q <= 9'h000;
			{div_q, dir_q, irq_en_q, io_out_q, io_on_q, pll_on_q} <= 15'h0000;
		end else if (wr_stb) begin
			age_q <= 9'h000;
			case (addr)
				ADDR_IRQ_EN:   irq_en_q <= wr_data[0];
				ADDR_CPU_CLOCK_DIVIDER_SELECT:   div_q <= wr_data[2:0];
				ADDR_XT_CTRL:  if (wr_data[0]) xt_out_q <= wr_data[2] & wr_data[1];
				ADDR_IO_CTRL:  {io_out_q, io_on_q} <= {wr_data[2], wr_data[0]};
				ADDR_PLL_CTRL: pll_on_q <= wr_data[0];
				ADDR_PIN_DIR:  dir_q <= wr_data[7:0];
				default: ;
			endcase
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst || por_rst);
	irq_pulse_a: assert property (crystal32_ready_irq |=> !crystal32_ready_irq)
		else $error("ready interrupt longer than one cycle");
	irq_gate_a: assert property (age_q > 9'h002 && crystal32_ready_irq |-> irq_en_q)
		else $error("ready interrupt while masked");
	cpu_period_a: assert property (age_q > 9'h12C && cpu_clk_en |-> gap_q == (8'h01 << div_q))
		else $error("cpu enable period wrong");
	pin_dir_a: assert property (age_q > 9'h003 |-> gen_clock_pin_oe_n == ~dir_q)
		else $error("pin drive does not follow direction");
	pin_src_a: assert property (age_q > 9'h008 |-> (gen_src_to_gen & dir_q) == 8'h00)
		else $error("output pin fed to generator");
	xt_gate_a: assert property (age_q > 9'h003 && xt_out_32k |-> xt_out_q)
		else $error("crystal 32k output without enable");
	io_gate_a: assert property (age_q > 9'h003 && io_out_32k |-> io_out_q && io_on_q)
		else $error("internal 32k output without enable");
	io_off_a: assert property (age_q > 9'h008 && !io_on_q |-> !io_clk)
		else $error("internal oscillator runs while off");
	pll_off_a: assert property (age_q > 9'h003 && !pll_on_q |-> !pll_out_clock)
		else $error("pll output while disabled");
	irq_seen_c: cover property ($rose(crystal32_ready_irq));
	slow_cpu_c: cover property (cpu_clk_en && div_q == 3'h7);
	pll_tick_c: cover property (pll_ref_clock ##[1:60] pll_out_clock);
	io_out_c: cover property ($rose(io_out_32k));
endmodule // csp_clock_ctrl_checker
bind csp_clock_ctrl csp_clock_ctrl_checker u_csp_clock_ctrl_checker (.ref_clk, .rst, .por_rst, .addr,
	.wr_data, .wr_stb, .cpu_clk_en, .gen_clock_pin_oe_n, .gen_src_to_gen, .xt_out_32k, .io_clk,
	.io_out_32k, .pll_ref_clock, .pll_out_clock, .crystal32_ready_irq);
`default_nettype wire

/* testbench/csp_osc_model.sv */
// far side: fitted 32k crystal, main oscillator, generic and lock-timer clocks
`timescale 1ns/1ps
`default_nettype none
module csp_osc_model #(
	parameter int XT_HALF   = 200,
	parameter int MAIN_HALF = 60,
	parameter int GEN_HALF  = 90,
	parameter int LOCK_HALF = 70
) (
	output var logic crystal_in_pin_32k,
	output var logic main_xosc_in,
	output var logic pll_ref_gen_clock,
	output var logic pll_lock_timer_clock
);
	// a real crystal, not a digital clock, so the 32k output is usable
	initial begin
		crystal_in_pin_32k = 1'b0;
		forever #(XT_HALF) crystal_in_pin_32k = ~crystal_in_pin_32k;
	end
	// slow enough that the divided reference stays in range
	initial begin
		main_xosc_in = 1'b0;
		forever #(MAIN_HALF) main_xosc_in = ~main_xosc_in;
	end
	initial begin
		pll_ref_gen_clock = 1'b0;
		forever #(GEN_HALF) pll_ref_gen_clock = ~pll_ref_gen_clock;
	end
	// lock-timer clock runs from time zero, before any pll use
	initial begin
		pll_lock_timer_clock = 1'b0;
		forever #(LOCK_HALF) pll_lock_timer_clock = ~pll_lock_timer_clock;
	end
endmodule // csp_osc_model
`default_nettype wire

/* testbench/tb_top.sv */
// self-checking bench for the clock source and pll control block
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import csp_pkg::*;
;
	localparam int         HALF      = 128;
	localparam logic [6:0] FACT_TRIM = 7'h40;
	localparam int         REF_EXP [3] = '{18, 15, 40};
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic        por_rst = 1'b1;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wr_data = 32'h0;
	logic        wr_stb = 1'b0;
	logic        rd_stb = 1'b0;
	logic [7:0]  gen_clock_pin_in = 8'h00;
	logic [7:0]  gen_clk_from_gen = 8'h00;
	logic [31:0] rd_data;
	logic [7:0]  gen_clock_pin_out, gen_clock_pin_oe_n, gen_src_to_gen;
	logic        cpu_clk_en, xt_clk, xt_out_32k, io_clk, io_out_32k;
	logic        pll_ref_clock, pll_out_clock, crystal32_ready_irq;
	logic        crystal_in_pin_32k, main_xosc_in, pll_ref_gen_clock, pll_lock_timer_clock;
	logic [5:0]  mon;
	int          num_errors = 0;
	int          samples_checked = 0;
	int          xe = 0;
	int          irq_n = 0;
	assign mon = {io_clk, io_out_32k, xt_out_32k, pll_out_clock, pll_ref_clock, cpu_clk_en};
	always #5 ref_clk = ~ref_clk;
	always @(posedge crystal_in_pin_32k) xe++;
	always @(posedge ref_clk) if (crystal32_ready_irq === 1'b1) irq_n++;
	csp_osc_model u_csp_osc_model (.crystal_in_pin_32k, .main_xosc_in, .pll_ref_gen_clock, .pll_lock_timer_clock);
	// short lock and oscillator counts keep the run brief
	csp_clock_ctrl #(.LOCK_EDGES(2), .HALF_NOM(HALF)) u_csp_clock_ctrl (.ref_clk, .rst, .por_rst, .addr,
		.wr_data, .wr_stb, .rd_stb, .rd_data, .crystal_in_pin_32k, .main_xosc_in, .pll_ref_gen_clock,
		.pll_lock_timer_clock, .gen_clock_pin_in, .gen_clock_pin_out, .gen_clock_pin_oe_n, .gen_clk_from_gen,
		.gen_src_to_gen, .cpu_clk_en, .xt_clk, .xt_out_32k, .io_clk, .io_out_32k, .pll_ref_clock,
		.pll_out_clock, .crystal32_ready_irq);
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		addr <= a;
		wr_data <= d;
		wr_stb <= 1'b1;
		@(posedge ref_clk);
		wr_stb <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge ref_clk);
		rd_stb <= 1'b0;
		#1 d = rd_data;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic near(input int got, input int exp, input int tol);
		samples_checked++;
		if (got < exp - tol || got > exp + tol) begin
			num_errors++;
			$display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wait_st(input int b, input logic v);
		logic [31:0] st;
		int n;
		n = 0;
		rd(ADDR_STATUS, st);
		while (st[b] !== v && n < 3000) begin
			rd(ADDR_STATUS, st);
			n++;
		end
		chk({31'h0, st[b]}, {31'h0, v});
	endtask
	task automatic cnt(input int s, input int n, output int c);
		c = 0;
		repeat (n) begin
			@(posedge ref_clk);
			#1 c += int'(mon[s] === 1'b1);
		end
	endtask
	task automatic hp(output int h);
		h = 0;
		@(negedge io_clk);
		while (io_clk !== 1'b1 && h < 4000) begin
			@(posedge ref_clk);
			#1 h++;
		end
	endtask
	task automatic rst_pulse(input logic por);
		@(posedge ref_clk);
		rst <= ~por;
		por_rst <= por;
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		por_rst <= 1'b0;
	endtask
	task automatic report_and_stop;
		$display("compared %0d values, %0d wrong", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// generous bound: the sequence needs well under a fifth of it
	initial begin
		#1000000;
		num_errors++;
		report_and_stop;
	end
	initial begin
		logic [31:0] d;
		int c;
		int h;
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		por_rst <= 1'b0;
		for (int a = 0; a < 9; a++) begin
			rd(8'(a * 4), d);
			chk(d, (a == 4) ? {9'h0, IO_TRIM_MID, 16'h0} : 32'h0);
		end
		$display("test reset values done");
		for (int i = 0; i < 8; i++) begin
			wr(ADDR_CPU_CLOCK_DIVIDER_SELECT, 32'hF8 | i);
			rd(ADDR_CPU_CLOCK_DIVIDER_SELECT, d);
			chk(d, 32'(i));
			repeat (256) @(posedge ref_clk);
			cnt(0, 256, c);
			near(c, 256 >> i, 0);
		end
		wr(ADDR_CPU_CLOCK_DIVIDER_SELECT, 32'h0);
		$display("test cpu divider done");
		for (int i = 0; i < 2; i++) begin
			wr(ADDR_IRQ_EN, 32'(i == 0));
			xe = 0;
			irq_n = 0;
			wr(ADDR_XT_CTRL, 32'h7 | (i << 8));
			wait (xe >= (4 << i));
			rd(ADDR_STATUS, d);
			chk({31'h0, d[0] | xt_clk}, 32'h0);
			wait_st(0, 1'b1);
			near(xe, 8 << i, 1);
			near(irq_n, 1 - i, 0);
			cnt(3, 400, c);
			near(c, 200, 4);
			if (i == 0) begin
				wr(ADDR_XT_CTRL, 32'h6);
				rd(ADDR_XT_CTRL, d);
				chk(d, 32'h6);
				wait_st(0, 1'b0);
			end
		end
		$display("test crystal start-up done");
		wr(ADDR_PLL_RATIO, 32'h3);
		for (int i = 0; i < 3; i++) begin
			wr(ADDR_PLL_CTRL, 32'h10001 | (i << 1));
			wait_st(2, 1'b1);
			cnt(1, 720, c);
			near(c, REF_EXP[i], 1);
		end
		wr(ADDR_PLL_CTRL, 32'h10003);
		// let two reference periods pass so the period measurement settles
		repeat (120) @(posedge ref_clk);
		for (int f = 0; f < 2; f++) begin
			wr(ADDR_PLL_RATIO, 32'h3 | (f << 19));
			rd(ADDR_STATUS, d);
			chk({31'h0, d[3]}, 32'(f));
			wait_st(2, 1'b1);
			cnt(2, 720, c);
			near(c, 60 + 8 * f, 3);
		end
		wr(ADDR_PLL_CTRL, 32'h0);
		cnt(2, 200, c);
		near(c, 0, 0);
		$display("test pll done");
		wr(ADDR_IO_CTRL, {9'h0, FACT_TRIM, 16'h5});
		wait_st(1, 1'b1);
		hp(h);
		near(h, HALF, 0);
		cnt(4, 512, c);
		near(c, 256, 2);
		wr(ADDR_IO_CTRL, {9'h0, FACT_TRIM + 7'h10, 16'h5});
		rd(ADDR_STATUS, d);
		chk({31'h0, d[1]}, 32'h0);
		wait_st(1, 1'b1);
		hp(h);
		hp(h);
		near(h, HALF + 16, 0);
		wr(ADDR_IO_CTRL, 32'h0);
		@(posedge ref_clk);
		cnt(5, 300, c);
		near(c, 0, 0);
		$display("test internal oscillator done");
		wr(ADDR_PIN_DIR, 32'h0F);
		for (int i = 0; i < 2; i++) begin
			@(posedge ref_clk);
			gen_clock_pin_in <= i ? 8'h5A : 8'hA5;
			gen_clk_from_gen <= i ? 8'hC3 : 8'h3C;
			repeat (8) @(posedge ref_clk);
			#1;
			chk({24'h0, gen_clock_pin_oe_n}, 32'hF0);
			chk({24'h0, gen_src_to_gen}, i ? 32'h50 : 32'hA0);
			chk({24'h0, gen_clock_pin_out & 8'h0F}, i ? 32'h03 : 32'h0C);
		end
		$display("test generic clock pins done");
		rst_pulse(1'b0);
		rd(ADDR_XT_CTRL, d);
		chk(d, 32'h107);
		rd(ADDR_STATUS, d);
		chk(d & 32'h1, 32'h1);
		cnt(3, 400, c);
		near(c, 200, 4);
		rst_pulse(1'b1);
		rd(ADDR_XT_CTRL, d);
		chk(d, 32'h0);
		cnt(3, 400, c);
		near(c, 0, 0);
		$display("test crystal across resets done");
		report_and_stop;
	end
endmodule // tb_top
`default_nettype wire
